/* src/cmd_fifo2.sv */
/*
  Two-entry buffer for array commands, valid/ready on both sides.
  Assumes the filler honours inReady and the drainer may stall freely.
*/
module cmd_fifo2 (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    inValid,
  output logic                         inReady,
  input  wire flash_cmd_pkg::cmd_entry_t inData,
  output logic                         outValid,
  input  wire logic                    outReady,
  output flash_cmd_pkg::cmd_entry_t    outData
);

  flash_cmd_pkg::buf_state_t q;
  flash_cmd_pkg::buf_state_t d;

  // Extra pointer bit tells full from empty
  assign outValid = (q.wrPtr != q.rdPtr);
  assign inReady  = (q.wrPtr != {~q.rdPtr[1], q.rdPtr[0]});
  assign outData  = q.rdPtr[0] ? q.mem1 : q.mem0;

  // Pointer and storage update
  always_comb begin
    d = q;
    if (inValid && inReady) begin
      if (q.wrPtr[0]) begin
        d.mem1 = inData;
      end else begin
        d.mem0 = inData;
      end
      d.wrPtr = q.wrPtr + 2'h1;
    end
    if (outValid && outReady) begin
      d.rdPtr = q.rdPtr + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

/* src/flash_cmd_cfg.svh */
/*
  Constants of the serial flash command front end: opcodes, status bit
  positions and reset values.
  Assumes it is included by bare name from the command front end module.
*/
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH

// Opcodes
`define OP_READ          8'h03
`define OP_FAST_READ     8'h0B
`define OP_SECTOR_ERASE  8'h20
`define OP_BLOCK_ERASE   8'hD8
`define OP_CHIP_ERASE_A  8'h60
`define OP_CHIP_ERASE_B  8'hC7
`define OP_PAGE_WRITE    8'h02
`define OP_STATUS_READ   8'h05
`define OP_STATUS_WRITE  8'h01
`define OP_WRITE_UNLOCK  8'h06
`define OP_WRITE_LOCK    8'h04

// Status bit positions
`define ST_BUSY_BIT      0
`define ST_LATCH_BIT     1
`define ST_LEVEL_LSB     2
`define ST_LEVEL_MSB     4
`define ST_TB_BIT        5
`define ST_LOCK_BIT      7

// Reset values
`define LEVEL_RST        3'h0
`define LOCK_RST         1'h0
`define TB_RST           1'h0
`define LATCH_RST        1'h0
// Synchronisers start at the idle pin levels: deselected, clock low
`define SYNC_RST         5'h13

// Frame layout
`define BITS_PER_CYCLE   3'h7
`define ADDR_BYTES_LAST  2'h2

`endif

/* src/flash_cmd_pkg.sv */
/*
  Types of the serial flash command front end.
  Assumes flash_cmd_cfg.svh is on the include path.
*/
package flash_cmd_pkg;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'h0,
    ST_ADDR   = 3'h1,
    ST_DUMMY  = 3'h2,
    ST_OUT    = 3'h3,
    ST_WSTAT  = 3'h4,
    ST_PROG   = 3'h5,
    ST_DONE   = 3'h6,
    ST_BAD    = 3'h7
  } frame_state_t;

  typedef enum logic [2:0] {
    K_WRITE_BYTE  = 3'h0,
    K_PROG_GO     = 3'h1,
    K_PROG_DROP   = 3'h2,
    K_ERASE_SECT  = 3'h3,
    K_ERASE_BLOCK = 3'h4,
    K_ERASE_CHIP  = 3'h5
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t   kind;
    logic [15:0] addr;
    logic [7:0]  data;
  } cmd_entry_t;

  typedef struct packed {
    logic [1:0]  wrPtr;
    logic [1:0]  rdPtr;
    cmd_entry_t  mem0;
    cmd_entry_t  mem1;
  } buf_state_t;

  typedef struct packed {
    logic [4:0]   s1;
    logic [4:0]   s2;
    logic [4:0]   s3;
    logic         paused;
    frame_state_t st;
    logic [7:0]   op;
    logic [2:0]   bitCnt;
    logic [1:0]   byteCnt;
    logic [6:0]   rx;
    logic [15:0]  addr;
    logic [7:0]   wdata;
    logic         progAny;
    logic         outActive;
    logic         loadPend;
    logic [6:0]   tx;
    logic         soBit;
    logic [2:0]   level;
    logic         tb;
    logic         lock;
    logic         latch;
    logic         pendValid;
    cmd_entry_t   pend;
  } core_state_t;

endpackage

/* src/serial_flash_protect_hold_cmd.sv */
/*
  Command front end of a small serial flash: frames serial instructions,
  keeps the protection bits, the write latch and the pause function, and
  hands array work to the user side through a two-entry buffer.
  Assumes all pins are asynchronous to mclk and the serial clock is well
  below mclk / 4; the array answers rdAddr on rdData within four mclk.
*/
`include "flash_cmd_cfg.svh"

module serial_flash_protect_hold_cmd (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      csN,
  input  wire logic                      sck,
  input  wire logic                      si,
  input  wire logic                      holdN,
  input  wire logic                      wpN,
  output logic                           so,
  output logic                           soOeN,
  input  wire logic                      arrayBusy,
  output logic [15:0]                    rdAddr,
  input  wire logic [7:0]                rdData,
  output logic                           cmdValid,
  input  wire logic                      cmdReady,
  output flash_cmd_pkg::cmd_kind_t       cmdKind,
  output logic [15:0]                    cmdAddr,
  output logic [7:0]                     cmdData,
  output logic                           writeLatch,
  output logic                           paused,
  output logic [7:0]                     statusByte
);

  flash_cmd_pkg::core_state_t q;
  flash_cmd_pkg::core_state_t d;
  flash_cmd_pkg::cmd_entry_t  bufOut;
  logic                       bufInReady;

  // Status byte in its documented layout
  function automatic logic [7:0] pack_status(
    input logic       lockB,
    input logic       tbB,
    input logic [2:0] levelB,
    input logic       latchB,
    input logic       busyB
  );
    pack_status = {lockB, 1'b0, tbB, levelB, latchB, busyB};
  endfunction

  // Any of the two low level bits protects the single 64 KB block
  function automatic logic array_protected(input logic [2:0] levelB);
    array_protected = levelB[0] | levelB[1];
  endfunction

  // Lock-down holds only with the pin low and the lock bit set
  function automatic logic status_writable(
    input logic wpB,
    input logic lockB
  );
    status_writable = wpB | ~lockB;
  endfunction

  // Pin view after the two synchroniser stages
  logic csS;
  logic sckS;
  logic siS;
  logic holdS;
  logic wpS;
  logic csRise;
  logic sckRise;
  logic sckFall;
  logic [7:0] rxByte;
  logic [7:0] txByte;

  assign csS     = q.s2[4];
  assign sckS    = q.s2[3];
  assign siS     = q.s2[2];
  assign holdS   = q.s2[1];
  assign wpS     = q.s2[0];
  assign csRise  = csS & ~q.s3[4];
  assign sckRise = sckS & ~q.s3[3];
  assign sckFall = ~sckS & q.s3[3];
  assign rxByte  = {q.rx, siS};   // MSB first
  assign txByte  = (q.op == `OP_STATUS_READ) ?
                   pack_status(q.lock, q.tb, q.level, q.latch, arrayBusy) :
                   rdData;

  // Next state of the whole front end
  always_comb begin
    d = q;
    d.s1 = {csN, sck, si, holdN, wpN};
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.pendValid && bufInReady) begin
      d.pendValid = 1'b0;
    end

    // Pause entry and exit wait for the clock's low phase
    if (!q.paused && !holdS && !sckS && !csS) begin
      d.paused = 1'b1;
    end else if (q.paused && holdS && !sckS) begin
      d.paused = 1'b0;
    end

    if (csRise) begin
      // Commit only whole frames, never from pause
      if (!q.paused && q.bitCnt == 3'h0 && q.st == flash_cmd_pkg::ST_DONE)
      begin
        unique case (q.op)
          `OP_WRITE_UNLOCK: d.latch = 1'b1;
          `OP_WRITE_LOCK:   d.latch = 1'b0;
          `OP_STATUS_WRITE: begin
            if (q.latch) begin
              if (status_writable(wpS, q.lock)) begin
                d.level = q.wdata[`ST_LEVEL_MSB:`ST_LEVEL_LSB];
                d.tb    = q.wdata[`ST_TB_BIT];
                d.lock  = q.wdata[`ST_LOCK_BIT];
              end
              d.latch = 1'b0;
            end
          end
          `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: begin
            if (q.latch && q.level == 3'h0) begin
              d.pendValid = 1'b1;
              d.pend      = '{flash_cmd_pkg::K_ERASE_CHIP, 16'h0000, 8'h00};
              d.latch     = 1'b0;
            end
          end
          `OP_SECTOR_ERASE, `OP_BLOCK_ERASE: begin
            if (q.latch && !array_protected(q.level)) begin
              d.pendValid = 1'b1;
              d.pend.kind = (q.op == `OP_SECTOR_ERASE) ?
                            flash_cmd_pkg::K_ERASE_SECT :
                            flash_cmd_pkg::K_ERASE_BLOCK;
              d.pend.addr = q.addr;
              d.pend.data = 8'h00;
              d.latch     = 1'b0;
            end
          end
          default: ;
        endcase
      end
      // Page write that queued a byte ends with a commit or, cut mid byte or ended in pause, a drop
      if (q.st == flash_cmd_pkg::ST_PROG && q.progAny) begin
        d.pendValid = 1'b1;
        d.pend.kind = (!q.paused && q.bitCnt == 3'h0) ?
                      flash_cmd_pkg::K_PROG_GO :
                      flash_cmd_pkg::K_PROG_DROP;
        d.pend.addr = q.addr;
        d.pend.data = 8'h00;
        if (!q.paused && q.bitCnt == 3'h0) begin
          d.latch = 1'b0;
        end
      end
      // Back to standby; pause itself follows the pause pin
      d.st        = flash_cmd_pkg::ST_OPCODE;
      d.bitCnt    = 3'h0;
      d.byteCnt   = 2'h0;
      d.progAny   = 1'b0;
      d.outActive = 1'b0;
      d.loadPend  = 1'b0;
    end else if (!csS && !q.paused) begin
      // Clock edges count only outside pause
      if (sckRise) begin
        d.rx     = rxByte[6:0];
        d.bitCnt = q.bitCnt + 3'h1;
        if (q.bitCnt == `BITS_PER_CYCLE) begin
          unique case (q.st)
            flash_cmd_pkg::ST_OPCODE: begin
              d.op      = rxByte;
              d.byteCnt = 2'h0;
              d.st      = flash_cmd_pkg::ST_BAD;
              if (!arrayBusy || rxByte == `OP_STATUS_READ) begin
                unique case (rxByte)
                  `OP_READ, `OP_FAST_READ, `OP_SECTOR_ERASE,
                  `OP_BLOCK_ERASE, `OP_PAGE_WRITE:
                    d.st = flash_cmd_pkg::ST_ADDR;
                  `OP_STATUS_READ: begin
                    d.st        = flash_cmd_pkg::ST_OUT;
                    d.outActive = 1'b1;
                    d.loadPend  = 1'b1;
                  end
                  `OP_STATUS_WRITE:
                    d.st = flash_cmd_pkg::ST_WSTAT;
                  `OP_WRITE_UNLOCK, `OP_WRITE_LOCK,
                  `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B:
                    d.st = flash_cmd_pkg::ST_DONE;
                  default: ;
                endcase
              end
            end
            flash_cmd_pkg::ST_ADDR: begin
              // Only the low sixteen address bits are kept
              d.addr    = {q.addr[7:0], rxByte};
              d.byteCnt = q.byteCnt + 2'h1;
              if (q.byteCnt == `ADDR_BYTES_LAST) begin
                unique case (q.op)
                  `OP_READ: begin
                    d.st        = flash_cmd_pkg::ST_OUT;
                    d.outActive = 1'b1;
                    d.loadPend  = 1'b1;
                  end
                  `OP_FAST_READ:  d.st = flash_cmd_pkg::ST_DUMMY;
                  `OP_PAGE_WRITE: d.st = flash_cmd_pkg::ST_PROG;
                  default:        d.st = flash_cmd_pkg::ST_DONE;
                endcase
              end
            end
            flash_cmd_pkg::ST_DUMMY: begin
              d.st        = flash_cmd_pkg::ST_OUT;
              d.outActive = 1'b1;
              d.loadPend  = 1'b1;
            end
            flash_cmd_pkg::ST_OUT: begin
              // Reads run on and wrap; status read repeats
              d.loadPend = 1'b1;
              if (q.op != `OP_STATUS_READ) begin
                d.addr = q.addr + 16'h0001;
              end
            end
            flash_cmd_pkg::ST_WSTAT: begin
              d.wdata = rxByte;
              d.st    = flash_cmd_pkg::ST_DONE;
            end
            flash_cmd_pkg::ST_PROG: begin
              // Bytes wrap inside the page; refused when protected
              if (q.latch && !array_protected(q.level)) begin
                d.pendValid = 1'b1;
                d.pend      = '{flash_cmd_pkg::K_WRITE_BYTE, q.addr, rxByte};
                d.progAny   = 1'b1;
              end
              d.addr[7:0] = q.addr[7:0] + 8'h01;
            end
            flash_cmd_pkg::ST_DONE: d.st = flash_cmd_pkg::ST_BAD;
            flash_cmd_pkg::ST_BAD:  ;
          endcase
        end
      end
      // Output bits change on falling edges, first bit at the load
      if (sckFall && q.outActive) begin
        if (q.loadPend) begin
          d.soBit    = txByte[7];
          d.tx       = txByte[6:0];
          d.loadPend = 1'b0;
        end else begin
          d.soBit = q.tx[6];
          d.tx    = {q.tx[5:0], 1'b0};
        end
      end
    end
  end

  // One register for all state but the buffer's; reset is power-up
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q       <= '0;
      q.s1    <= `SYNC_RST;   // Idle levels, so no false clock edge
      q.s2    <= `SYNC_RST;
      q.s3    <= `SYNC_RST;
      q.level <= `LEVEL_RST;
      q.lock  <= `LOCK_RST;
      q.tb    <= `TB_RST;
      q.latch <= `LATCH_RST;
    end else begin
      q <= d;
    end
  end

  // Buffer absorbs user-side stalls; the pending slot waits on it
  cmd_fifo2 u_fifo (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .inValid  (q.pendValid),
    .inReady  (bufInReady),
    .inData   (q.pend),
    .outValid (cmdValid),
    .outReady (cmdReady),
    .outData  (bufOut)
  );

  // Output released in pause or outside a data phase
  assign so         = q.soBit;
  assign soOeN      = ~(q.outActive & ~q.paused & ~csS);
  assign rdAddr     = q.addr;
  assign cmdKind    = bufOut.kind;
  assign cmdAddr    = bufOut.addr;
  assign cmdData    = bufOut.data;
  assign writeLatch = q.latch;
  assign paused     = q.paused;
  assign statusByte = pack_status(q.lock, q.tb, q.level, q.latch, arrayBusy);

endmodule

/* testbench/flash_cmd_checker.sv */
/*
  Concurrent checks on the pins of the serial flash command front end.
  Assumes a bind from the bench top and pins that change off mclk edges.
*/
module flash_cmd_checker (
  input wire logic                     mclk,
  input wire logic                     rst_n,
  input wire logic                     csN,
  input wire logic                     sck,
  input wire logic                     holdN,
  input wire logic                     wpN,
  input wire logic                     soOeN,
  input wire logic                     arrayBusy,
  input wire logic                     cmdValid,
  input wire logic                     cmdReady,
  input wire flash_cmd_pkg::cmd_kind_t cmdKind,
  input wire logic [15:0]              cmdAddr,
  input wire logic [7:0]               cmdData,
  input wire logic                     writeLatch,
  input wire logic                     paused,
  input wire logic [7:0]               statusByte
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Pause states; pins are held long, so one cycle back is safe
  AST_OE_PAUSE: assert property (paused && $past(paused) |-> soOeN)
    else $error("so driven while paused");
  AST_PAUSE_START: assert property ($rose(paused) |->
    !$past(holdN) && !$past(sck) && !$past(csN))
    else $error("pause entered without hold low at clock low");
  AST_PAUSE_END: assert property ($fell(paused) |->
    $past(holdN) && !$past(sck))
    else $error("pause left without hold high at clock low");

  // Latch and protection only move once select is back high
  AST_LATCH_COMMIT: assert property ($changed(writeLatch) |-> csN)
    else $error("write latch moved inside a frame");
  AST_LOCK_FREEZE: assert property (
    !wpN && statusByte[7] |=> $stable(statusByte[7:2]))
    else $error("locked protection bits changed");
  AST_CHIP_ERASE: assert property (
    cmdValid && cmdKind == flash_cmd_pkg::K_ERASE_CHIP
    |-> statusByte[4:2] == 3'h0)
    else $error("whole erase issued while protected");
  AST_STATUS_MAP: assert property (
    statusByte[1] == writeLatch && !statusByte[6]
    && statusByte[0] == arrayBusy)
    else $error("status byte layout wrong");
  AST_IDLE_OE: assert property (csN [*8] |-> soOeN)
    else $error("so driven while deselected");
  // A stalled entry must not change under the drainer
  AST_BUF_HOLD: assert property (cmdValid && !cmdReady |=>
    cmdValid && $stable({cmdKind, cmdAddr, cmdData}))
    else $error("buffer entry changed while stalled");

  // Main scenarios reached
  cover property ($rose(paused));
  cover property (cmdValid && cmdReady
    && cmdKind == flash_cmd_pkg::K_PROG_GO);
  cover property ($fell(writeLatch));
endmodule

/* testbench/serial_flash_protect_hold_cmd_tb.sv */
/*
  Self-checking bench of the serial flash command front end.
  Assumes the host model drives the serial pins and a small array
  model answers rdAddr one clock later.
*/
module serial_flash_protect_hold_cmd_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                     mclk, rst_n, wpN, arrayBusy, cmdReady;
  logic                     csN, sck, si, holdN, so, soOeN, soLine;
  logic                     cmdValid, writeLatch, paused;
  logic [15:0]              rdAddr, cmdAddr;
  logic [7:0]               rdData, cmdData, statusByte, r;
  logic [7:0]               rx[$];
  flash_cmd_pkg::cmd_kind_t cmdKind;
  int                       checks, miscompares;
  logic [7:0]               ops[4] = '{8'h60, 8'hC7, 8'h20, 8'hD8};
  flash_cmd_pkg::cmd_kind_t kinds[4] = '{flash_cmd_pkg::K_ERASE_CHIP,
    flash_cmd_pkg::K_ERASE_CHIP, flash_cmd_pkg::K_ERASE_SECT,
    flash_cmd_pkg::K_ERASE_BLOCK};

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Pull-up on so once released
  assign soLine = soOeN ? 1'b1 : so;

  // Array stand-in: data is a fixed function of the address
  initial rdData = 8'h00;
  always @(posedge mclk) rdData <= #1 rdAddr[7:0] ^ 8'hA5;

  serial_flash_protect_hold_cmd i_serial_flash_protect_hold_cmd (
    .mclk(mclk), .rst_n(rst_n), .csN(csN), .sck(sck), .si(si),
    .holdN(holdN), .wpN(wpN), .so(so), .soOeN(soOeN),
    .arrayBusy(arrayBusy), .rdAddr(rdAddr), .rdData(rdData),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .writeLatch(writeLatch),
    .paused(paused), .statusByte(statusByte));

  spi_host_model i_spi_host_model (
    .csN(csN), .sck(sck), .si(si), .holdN(holdN), .so(soLine));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic fr(input logic [7:0] b[$], input int last = 8);
    i_spi_host_model.frame(b, last, rx);
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Wait bounded for an entry, compare it, then accept it
  task automatic take(input flash_cmd_pkg::cmd_kind_t k,
                      input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmdValid !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    if (cmdValid !== 1'b1) begin
      miscompares++;
      summarize();
    end
    chk(16'(cmdKind), 16'(k), "cmdKind");
    if (k == flash_cmd_pkg::K_WRITE_BYTE || k == flash_cmd_pkg::K_ERASE_SECT
        || k == flash_cmd_pkg::K_ERASE_BLOCK)
      chk(cmdAddr, a, "cmdAddr");
    if (k == flash_cmd_pkg::K_WRITE_BYTE)
      chk(cmdData, d, "cmdData");
    cmdReady = 1'b1;
    tick(1);
    cmdReady = 1'b0;
  endtask

  initial begin
    rst_n = 1'b0;
    wpN = 1'b1;
    arrayBusy = 1'b0;
    cmdReady = 1'b0;
    checks = 0;
    miscompares = 0;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    tick(4);
    chk(statusByte, 8'h00, "status");
    arrayBusy = 1'b1;
    tick(2);
    chk(statusByte, 8'h01, "status");
    arrayBusy = 1'b0;
    $display("reset done");

    fr('{8'h06});
    chk(writeLatch, 1, "latch");
    fr('{8'h05, 8'h00, 8'h00});
    chk(rx[2], 8'h02, "status");
    fr('{8'h06});
    fr('{8'h01, 8'h9C});
    chk(statusByte, 8'h9C, "status");
    fr('{8'h06});
    fr('{8'h60});
    tick(40);
    chk(cmdValid, 0, "cmdValid");
    wpN = 1'b0;
    fr('{8'h06});
    fr('{8'h01, 8'h00});
    chk(statusByte, 8'h9C, "status");
    wpN = 1'b1;
    fr('{8'h06});
    fr('{8'h01, 8'h00});
    chk(statusByte, 8'h00, "status");
    $display("protection done");

    // Every erase opcode, latch dropped after each
    for (int j = 0; j < 4; j++) begin
      fr('{8'h06});
      if (j < 2)
        fr('{ops[j]});
      else
        fr('{ops[j], 8'hAB, 8'h34, 8'h56});
      take(kinds[j], 16'h3456, 8'h00);
      chk(writeLatch, 0, "latch");
    end
    // Page write stays queued while the user stalls
    fr('{8'h06});
    fr('{8'h02, 8'hAA, 8'h00, 8'h10, 8'hAB, 8'hCD});
    take(flash_cmd_pkg::K_WRITE_BYTE, 16'h0010, 8'hAB);
    take(flash_cmd_pkg::K_WRITE_BYTE, 16'h0011, 8'hCD);
    take(flash_cmd_pkg::K_PROG_GO, 16'h0000, 8'h00);
    // Page write cut inside its second data byte
    fr('{8'h06});
    fr('{8'h02, 8'h00, 8'h00, 8'h20, 8'h11, 8'h22}, 4);
    take(flash_cmd_pkg::K_WRITE_BYTE, 16'h0020, 8'h11);
    take(flash_cmd_pkg::K_PROG_DROP, 16'h0000, 8'h00);
    chk(writeLatch, 1, "latch");
    fr('{8'h06});
    fr('{8'h20, 8'h12}, 4);
    tick(40);
    chk(cmdValid, 0, "cmdValid");
    fr('{8'h20, 8'h00, 8'h10, 8'h00});
    take(flash_cmd_pkg::K_ERASE_SECT, 16'h1000, 8'h00);
    $display("array commands done");

    fr('{8'h03, 8'hFF, 8'h12, 8'h40, 8'h00, 8'h00});
    chk(rx[4], 8'hE5, "read");
    chk(rx[5], 8'hE4, "read");
    fr('{8'h0B, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00});
    chk(rx[5], 8'h5A, "fastread");
    chk(rx[6], 8'hA5, "fastread");
    $display("reads done");

    // Pause inside a status read, then select rise while paused
    fr('{8'h06});
    i_spi_host_model.pins(1'b0, 1'b0, 1'b1);
    i_spi_host_model.xbits(8'h05, 8, r);
    i_spi_host_model.pins(1'b0, 1'b1, 1'b1);
    tick(10);
    i_spi_host_model.pins(1'b0, 1'b1, 1'b0);
    tick(10);
    chk(paused, 0, "paused");
    i_spi_host_model.pins(1'b0, 1'b0, 1'b0);
    tick(10);
    chk(paused, 1, "paused");
    chk(soOeN, 1, "soOeN");
    i_spi_host_model.xbits(8'hFF, 8, r);
    i_spi_host_model.pins(1'b0, 1'b0, 1'b1);
    tick(10);
    chk(paused, 0, "paused");
    i_spi_host_model.xbits(8'h00, 8, r);
    // One clock rise went unsampled before the pause: bits come shifted left by one
    chk(r, 8'h04, "status");
    i_spi_host_model.pins(1'b0, 1'b0, 1'b0);
    tick(10);
    chk(paused, 1, "paused");
    i_spi_host_model.pins(1'b1, 1'b0, 1'b0);
    tick(10);
    chk(paused, 1, "paused");
    i_spi_host_model.pins(1'b1, 1'b0, 1'b1);
    tick(10);
    fr('{8'h05, 8'h00});
    chk(rx[1], 8'h02, "status");
    $display("pause done");
    summarize();
  end
endmodule

bind serial_flash_protect_hold_cmd flash_cmd_checker i_flash_cmd_checker (
  .mclk, .rst_n, .csN, .sck, .holdN, .wpN, .soOeN, .arrayBusy,
  .cmdValid, .cmdReady, .cmdKind, .cmdAddr, .cmdData, .writeLatch,
  .paused, .statusByte);

/* testbench/spi_host_model.sv */
/*
  Behavioural serial host in mode 0: frames bytes MSB first.
  Assumes so is already resolved, released meaning pulled high.
*/
module spi_host_model (
  output logic     csN,
  output logic     sck,
  output logic     si,
  output logic     holdN,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: deselected, clock parked low between frames
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    holdN = 1'b1;
  end

  // Direct pin control for pause sequences
  task automatic pins(input logic c, input logic k, input logic h);
    // Settle first, so a clock phase is never cut to zero width
    #100;
    csN = c;
    sck = k;
    holdN = h;
  endtask

  // Shift n bits, MSB first; si set while clock low, so taken at rise
  task automatic xbits(input logic [7:0] tx, input int n,
                       output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i >= 8 - n; i--) begin
      si = tx[i];
      #62.5 sck = 1'b1;
      r[i] = so;
      #62.5 sck = 1'b0;
    end
  endtask

  // Whole frame; a short last byte makes an early select rise
  task automatic frame(input logic [7:0] b[$], input int last,
                       output logic [7:0] rx[$]);
    logic [7:0] r;
    rx.delete();
    csN = 1'b0;
    #100;
    foreach (b[k]) begin
      xbits(b[k], (k == b.size() - 1) ? last : 8, r);
      rx.push_back(r);
    end
    #100 csN = 1'b1;
    si = ~si; // Released line must not keep its last level
    #400;
  endtask
endmodule
